// ### src/ltd_cmd.v
// Purpose: decode legacy transmit descriptor, delay transmit interrupt,
//          compute the inserted checksum, produce done write-back
// Assumes: packet bytes stream in after each descriptor, one byte a cycle
// Notes: one packet in flight at a time
//
// Functional notes
// R1 - Checksum start offset counts bytes from packet's first byte, zero is first.
// R2 - Software sets start offset in first descriptor, below length and unpadded length.
// R3 - Odd start and insertion offsets accepted; summing uses 16-bit words.
// R4 - Inserted VLAN type and tag words never enter the checksum.
// R5 - Software writes zero into the reserved descriptor field.
// R6 - Command bits 7 to 0: delay, vlan, extended, late report, report, checksum, fcs, last.
// R7 - Write-back with report and delay enable loads countdown from delay value field.
// R8 - Countdown reaching zero raises transmit interrupt when write-back irq unmasked.
// R9 - Countdown reloads on every delay-enabled descriptor, even while running; here it reloads only when such a descriptor is written back.
// R10 - Report without delay raises interrupt after write-back and clears timer.
// R11 - VLAN insert adds type from register, tag from special field, always adds FCS.
// R12 - Without VLAN insert packet is untagged; FCS follows frame check insert bit.
// R13 - VLAN insert needs vlan mode enable and counts only on last descriptor.
// R14 - Extended format bit zero selects legacy layout; software writes zero.
// R15 - Report-after-sent postpones done flag until sent or ended in error.
// R16 - While report-after-sent pends, no head advance and no other write-back.
// R17 - Report-after-sent honoured only on last descriptor; zero where unsupported.
// R18 - Report completion writes done flag once descriptor data is buffered.
// R19 - Software should prefer context-style extended descriptors for checksum offload.
// R20 - Last descriptor flag closes packet; several descriptors may form one packet.
// R21 - Checksum insert on last descriptor computes from start, places at insert offset.
// R22 - Frame check insert honoured only on last descriptor for untagged packets.
// R23 - Done flag is bit zero of result flags byte, set at write-back.
// R24 - Checksum is complement of ones'-complement word sum, odd byte zero padded.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ltd_consts.vh"
module ltd_cmd (
    input wire clk,
    input wire rst_n,
    // Classic Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Fetched descriptor
    input wire desc_valid,
    input wire [63:0] desc_hi,
    output wire desc_ready,
    // Packet byte stream of the current descriptor
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire byte_last,
    // MAC transmit outcome
    input wire sent_ok,
    input wire sent_err,
    // Write-back and head advance
    output reg wb_done_valid,
    output reg [7:0] result_flags_byte,
    output reg head_advance,
    // Per-packet decisions
    output reg pkt_valid,
    output reg pkt_vlan,
    output reg [15:0] pkt_vlan_type,
    output reg [15:0] pkt_vlan_tag,
    output reg pkt_fcs,
    output reg pkt_csum_valid,
    output reg [15:0] pkt_csum,
    output reg [7:0] pkt_csum_offset,
    output reg tx_irq
);
    // ****************************************************
    // Registers and state
    // ****************************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_DATA = 2'd1;
    localparam ST_WAIT = 2'd2;
    reg [1:0] state_q;
    reg [31:0] ctrl_q;
    reg [15:0] delay_q;
    reg [15:0] vtype_q;
    reg [15:0] count_q;
    reg counting_q;
    reg [7:0] cmd_q;
    reg [15:0] len_q;
    reg [7:0] cso_q;
    reg [15:0] spc_q;
    reg [15:0] pos_q;
    reg [16:0] sum_q;
    reg [7:0] hi_byte_q;
    reg odd_q;
    reg first_q;
    reg [7:0] csum_start_q;
    // ****************************************************
    // Helpers
    // ****************************************************
    // End-around carry add keeps the sum in ones' complement
    function [16:0] oc_add;
        input [16:0] a;
        input [15:0] b;
        reg [16:0] t;
        begin
            t = {1'b0, a[15:0]} + {1'b0, b};
            oc_add = {1'b0, t[15:0] + {15'h0000, t[16]}};
        end
    endfunction
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire vlan_mode_enable = ctrl_q[`LTD_CTRL_VLAN_EN];
    wire mask_on = ctrl_q[`LTD_CTRL_MASK];
    wire late_sup = ctrl_q[`LTD_CTRL_LATE_SUP];
    wire [7:0] dcmd = desc_hi[`LTD_CMD_LSB +: 8];
    wire last_descriptor_flag = cmd_q[`LTD_CMD_LAST]; // R20
    wire legacy = ~cmd_q[`LTD_CMD_EXT]; // R14
    wire report_completion = cmd_q[`LTD_CMD_REPORT]; // R6
    wire delayed_interrupt_enable = cmd_q[`LTD_CMD_DELAY];
    // Late report counts only on a legacy last descriptor of a capable part
    wire report_after_sent = cmd_q[`LTD_CMD_LATE] & last_descriptor_flag & late_sup &
                             legacy; // R17
    wire vlan_on = legacy & vlan_mode_enable & cmd_q[`LTD_CMD_VLAN]; // R13
    // Byte position inside packet at or past start offset
    wire in_sum = (pos_q >= {8'h00, csum_start_q}); // R1 R3
    // Sum and length with this cycle's byte taken in; the last byte
    // arrives on the same edge that reports the checksum
    wire take_byte = byte_valid & in_sum;
    wire [16:0] sum_nx = (take_byte & odd_q) ? oc_add(sum_q, {hi_byte_q, byte_data}) : sum_q;
    wire odd_nx = take_byte ^ odd_q;
    wire [7:0] hi_nx = (take_byte & ~odd_q) ? byte_data : hi_byte_q;
    wire [15:0] len_nx = byte_valid ? pos_q + 16'h0001 : pos_q;
    // Flushed sum, padding a pending odd byte with zero
    wire [16:0] sum_fin = odd_nx ? oc_add(sum_nx, {hi_nx, 8'h00}) : sum_nx; // R24
    // Checksum valid only when offsets sit inside the packet
    wire cs_ok = ({8'h00, csum_start_q} < len_nx) & ({8'h00, cso_q} < len_nx - 16'h0001);
    assign desc_ready = (state_q == ST_IDLE);
    // ****************************************************
    // Wishbone slave, one registered ack per request, a cycle after it
    // ****************************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_q <= `LTD_CTRL_RST;
            delay_q <= `LTD_DELAY_RST;
            vtype_q <= `LTD_VTYPE_RST;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && wb_we_i) begin
                case (wb_adr_i)
                    `LTD_REG_CTRL: begin
                        if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
                    end
                    `LTD_REG_DELAY: begin
                        if (wb_sel_i[0]) delay_q[7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1]) delay_q[15:8] <= wb_dat_i[15:8];
                    end
                    `LTD_REG_VTYPE: begin
                        if (wb_sel_i[0]) vtype_q[7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1]) vtype_q[15:8] <= wb_dat_i[15:8];
                    end
                    default: begin
                    end
                endcase
            end
            // Unmapped addresses read as zero
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `LTD_REG_CTRL: wb_dat_o <= {24'h000000, ctrl_q[7:0]};
                    `LTD_REG_DELAY: wb_dat_o <= {16'h0000, delay_q};
                    `LTD_REG_VTYPE: wb_dat_o <= {16'h0000, vtype_q};
                    `LTD_REG_STAT: wb_dat_o <= {count_q, 12'h000, counting_q,
                                                tx_irq, state_q};
                    `LTD_REG_CSUM: wb_dat_o <= {8'h00, pkt_csum_offset, pkt_csum};
                    `LTD_REG_TAG: wb_dat_o <= {pkt_vlan_type, pkt_vlan_tag};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    // ****************************************************
    // Descriptor processing
    // ****************************************************
    // Waiting state holds back head and any later write-back
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cmd_q <= 8'h00;
            len_q <= 16'h0000;
            cso_q <= 8'h00;
            spc_q <= 16'h0000;
            pos_q <= 16'h0000;
            sum_q <= 17'h00000;
            hi_byte_q <= 8'h00;
            odd_q <= 1'b0;
            first_q <= 1'b1;
            csum_start_q <= 8'h00;
            wb_done_valid <= 1'b0;
            result_flags_byte <= 8'h00;
            head_advance <= 1'b0;
            pkt_valid <= 1'b0;
            pkt_vlan <= 1'b0;
            pkt_vlan_type <= 16'h0000;
            pkt_vlan_tag <= 16'h0000;
            pkt_fcs <= 1'b0;
            pkt_csum_valid <= 1'b0;
            pkt_csum <= 16'h0000;
            pkt_csum_offset <= 8'h00;
        end else begin
            wb_done_valid <= 1'b0;
            head_advance <= 1'b0;
            pkt_valid <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (desc_valid) begin
                        cmd_q <= dcmd; // R6
                        len_q <= desc_hi[`LTD_LEN_LSB +: 16];
                        cso_q <= desc_hi[`LTD_CSO_LSB +: 8];
                        spc_q <= desc_hi[`LTD_SPC_LSB +: 16];
                        // Start offset latched from first descriptor only
                        if (first_q) begin
                            csum_start_q <= desc_hi[`LTD_START_LSB +: 8]; // R1
                        end
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    // Stream holds only payload; inserted tag never summed
                    if (byte_valid) begin // R4
                        pos_q <= pos_q + 16'h0001;
                        if (in_sum) begin
                            if (odd_q) begin
                                sum_q <= oc_add(sum_q, {hi_byte_q, byte_data}); // R3
                                odd_q <= 1'b0;
                            end else begin
                                hi_byte_q <= byte_data;
                                odd_q <= 1'b1;
                            end
                        end
                    end
                    // Zero-length descriptors skip straight to completion
                    if ((byte_valid && byte_last) || len_q == 16'h0000) begin
                        if (report_after_sent) begin
                            state_q <= ST_WAIT; // R15
                        end else begin
                            state_q <= ST_IDLE;
                            head_advance <= 1'b1;
                            wb_done_valid <= report_completion; // R18
                            result_flags_byte <= {7'h00, report_completion}; // R23
                        end
                        first_q <= last_descriptor_flag;
                        if (last_descriptor_flag) begin // R20
                            pkt_valid <= 1'b1;
                            pkt_vlan <= vlan_on; // R13
                            pkt_vlan_type <= vtype_q; // R11
                            pkt_vlan_tag <= spc_q;
                            // Tagged frames always carry FCS
                            pkt_fcs <= vlan_on | cmd_q[`LTD_CMD_FCS]; // R11 R12 R22
                            pkt_csum_valid <= cmd_q[`LTD_CMD_CSUM] & cs_ok; // R21
                            pkt_csum <= ~sum_fin[15:0]; // R24
                            pkt_csum_offset <= cso_q;
                            pos_q <= 16'h0000;
                            sum_q <= 17'h00000;
                            odd_q <= 1'b0;
                        end
                    end
                end
                ST_WAIT: begin
                    // Error ends the wait just like a clean send
                    if (sent_ok || sent_err) begin // R15 R16
                        state_q <= ST_IDLE;
                        head_advance <= 1'b1;
                        wb_done_valid <= 1'b1;
                        result_flags_byte <= {6'h00, sent_err, 1'b1}; // R23
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // ****************************************************
    // Transmit interrupt delay
    // ****************************************************
    // Reload on every delay-enabled report, even mid-count
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            counting_q <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            tx_irq <= 1'b0;
            if (wb_done_valid && delayed_interrupt_enable) begin
                count_q <= delay_q; // R7 R9
                counting_q <= 1'b1;
            end else if (wb_done_valid) begin
                count_q <= 16'h0000; // R10
                counting_q <= 1'b0;
                tx_irq <= mask_on;
            end else if (counting_q) begin
                if (count_q <= 16'h0001) begin
                    counting_q <= 1'b0;
                    count_q <= 16'h0000;
                    tx_irq <= mask_on; // R8
                end else begin
                    count_q <= count_q - 16'h0001;
                end
            end
        end
    end
endmodule // ltd_cmd
`default_nettype wire

// ### src/ltd_consts.vh
// Purpose: constants for the legacy transmit descriptor command block
// Assumes: 128-bit legacy descriptor, classic Wishbone register port
// Notes: offsets are byte addresses on a 32-bit bus
`ifndef LTD_CONSTS_VH
`define LTD_CONSTS_VH
// Command byte bit positions
`define LTD_CMD_LAST 0
`define LTD_CMD_FCS 1
`define LTD_CMD_CSUM 2
`define LTD_CMD_REPORT 3
`define LTD_CMD_LATE 4
`define LTD_CMD_EXT 5
`define LTD_CMD_VLAN 6
`define LTD_CMD_DELAY 7
// Descriptor field positions in the upper 64-bit word
`define LTD_LEN_LSB 0
`define LTD_CSO_LSB 16
`define LTD_CMD_LSB 24
`define LTD_FLAGS_LSB 32
`define LTD_START_LSB 40
`define LTD_SPC_LSB 48
`define LTD_DONE_BIT 0
// Register byte offsets
`define LTD_REG_CTRL 6'h00
`define LTD_REG_DELAY 6'h04
`define LTD_REG_VTYPE 6'h08
`define LTD_REG_STAT 6'h0c
`define LTD_REG_CSUM 6'h10
`define LTD_REG_TAG 6'h14
// Reset values
`define LTD_CTRL_RST 32'h0000_0000
`define LTD_DELAY_RST 16'h0000
`define LTD_VTYPE_RST 16'h8100
// Control bit positions
`define LTD_CTRL_VLAN_EN 0
`define LTD_CTRL_MASK 1
`define LTD_CTRL_LATE_SUP 2
`endif

// ### verification/ltd_cmd_sva.sv
// Purpose: concurrent checks on the legacy transmit descriptor block
// Assumes: one clock, asynchronous active-low reset
// Notes: command and control bits are shadowed from the ports
`timescale 1ns/1ps
`default_nettype none
module ltd_cmd_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic desc_valid,
    input wire logic desc_ready,
    input wire logic [63:0] desc_hi,
    input wire logic sent_ok,
    input wire logic sent_err,
    input wire logic wb_done_valid,
    input wire logic [7:0] result_flags_byte,
    input wire logic head_advance,
    input wire logic pkt_valid,
    input wire logic pkt_vlan,
    input wire logic pkt_fcs,
    input wire logic tx_irq
);
    logic [7:0] cmd_q;
    logic [2:0] ctrl_q;
    logic pend_q;
    // The control shadow lags the block by a cycle; checks avoid that edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= 8'h00;
            ctrl_q <= 3'h0;
            pend_q <= 1'b0;
        end else begin
            if (desc_valid && desc_ready)
                cmd_q <= desc_hi[31:24];
            if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 6'h00 && wb_sel_i[0])
                ctrl_q <= wb_dat_i[2:0];
            if (sent_ok || sent_err)
                pend_q <= 1'b0;
            else if (desc_valid && desc_ready && ctrl_q[2] && desc_hi[28] && desc_hi[24])
                pend_q <= !desc_hi[29];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    done_flag_a: assert property (wb_done_valid |-> result_flags_byte[0])
        else $error("write-back without done flag");
    done_cause_a: assert property (wb_done_valid |-> cmd_q[3] || cmd_q[4])
        else $error("write-back without report request");
    irq_now_a: assert property (wb_done_valid && cmd_q[3] && !cmd_q[7] && ctrl_q[1] |=> tx_irq)
        else $error("no immediate interrupt");
    irq_mask_a: assert property (tx_irq |-> ctrl_q[1] || $past(ctrl_q[1]))
        else $error("interrupt while masked");
    vlan_fcs_a: assert property (pkt_valid && pkt_vlan |-> pkt_fcs)
        else $error("tagged packet without frame check");
    vlan_gate_a: assert property (pkt_valid && pkt_vlan |-> ctrl_q[0] && cmd_q[6])
        else $error("tag inserted without enable");
    fcs_plain_a: assert property (pkt_valid && !pkt_vlan |-> pkt_fcs == cmd_q[1])
        else $error("frame check not following insert bit");
    late_hold_a: assert property (pend_q |-> !head_advance && !wb_done_valid)
        else $error("head moved before packet sent");
endmodule // ltd_cmd_sva
bind ltd_cmd ltd_cmd_sva chk_u (.*);
`default_nettype wire

// ### verification/ltd_host_model.sv
// Purpose: host memory side, feeds descriptors and their packet bytes
// Assumes: the block takes a byte on every cycle that byte_valid is high
// Notes: idle lines show the inverse of the last value, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module ltd_host_model (
    input wire logic clk,
    input wire logic desc_ready,
    output logic desc_valid = 1'b0,
    output logic [63:0] desc_hi = 64'h0,
    output logic byte_valid = 1'b0,
    output logic [7:0] byte_data = 8'h00,
    output logic byte_last = 1'b0
);
    function automatic logic [7:0] pat(input int i);
        return 8'(8'h35 + i * 29);
    endfunction
    // Hold the descriptor until taken, then stream bytes, gap idles between
    task automatic send(input logic [63:0] d, input int n, input int gap, input int base);
        int k;
        desc_valid <= 1'b1;
        desc_hi <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (desc_ready !== 1'b1 && k < 200);
        // A descriptor never taken is a hang, not a quiet skip
        if (desc_ready !== 1'b1) begin
            tb.errors++;
            tb.final_report();
        end
        desc_valid <= 1'b0;
        desc_hi <= ~d;
        for (int i = 0; i < n; i++) begin
            byte_valid <= 1'b1;
            byte_data <= pat(base + i);
            byte_last <= i == n - 1;
            @(posedge clk);
            if (gap > 0 || i == n - 1) begin
                byte_valid <= 1'b0;
                byte_data <= ~pat(base + i);
                byte_last <= 1'b0;
                repeat (gap) @(posedge clk);
            end
        end
    endtask
endmodule // ltd_host_model
`default_nettype wire

// ### verification/tb.sv
// Purpose: self-checking bench for the legacy transmit descriptor block
// Assumes: one clock, registers over classic Wishbone
// Notes: bytes follow the host model pattern, so checksums are predictable
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, sent_ok = 1'b0, sent_err = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, desc_valid, desc_ready, byte_valid, byte_last, wb_done_valid, head_advance;
    logic pkt_valid, pkt_vlan, pkt_fcs, pkt_csum_valid, tx_irq;
    logic [63:0] desc_hi, snap;
    logic [7:0] byte_data, result_flags_byte, pkt_csum_offset, flags_s;
    logic [15:0] pkt_vlan_type, pkt_vlan_tag, pkt_csum;
    int errors = 0, n_checks = 0, cyc_n = 0, n_done = 0, n_head = 0, n_irq = 0, n_pkt = 0;
    int t_done = 0, t_irq = 0, p0, d0, h0, i0;
    logic [7:0] cm [4] = '{8'h41, 8'h41, 8'h03, 8'h01};
    logic [2:0] ex [4] = '{3'b110, 3'b000, 3'b010, 3'b000};
    ltd_cmd dut_u (.*);
    ltd_host_model host_u (.*);
    always #2 clk = ~clk;
    // Count pulses at the edge, so nothing races the block's own updates
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (wb_done_valid === 1'b1) begin
            n_done <= n_done + 1;
            t_done <= cyc_n;
            flags_s <= result_flags_byte;
        end
        if (head_advance === 1'b1)
            n_head <= n_head + 1;
        if (tx_irq === 1'b1) begin
            n_irq <= n_irq + 1;
            t_irq <= cyc_n;
        end
        if (pkt_valid === 1'b1) begin
            n_pkt <= n_pkt + 1;
            snap <= {5'h0, pkt_vlan, pkt_fcs, pkt_csum_valid, pkt_vlan_type, pkt_vlan_tag,
                pkt_csum, pkt_csum_offset};
        end
    end
    task final_report;
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, exp, m = '1);
        n_checks++;
        if ((seen & m) !== (exp & m)) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(ref int c, input int tgt);
        for (int k = 0; k < 300 && c < tgt; k++)
            @(posedge clk);
        if (c < tgt) begin
            errors++;
            final_report();
        end
    endtask
    task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o;
        if (k >= 50) begin
            errors++;
            final_report();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    task mark;
        p0 = n_pkt;
        d0 = n_done;
        h0 = n_head;
        i0 = n_irq;
    endtask
    // Status and reserved bytes always zero, extended select left at legacy
    function automatic logic [63:0] mk(input logic [15:0] len, input logic [7:0] cso, cmd, start,
        input logic [15:0] spc);
        return {spc, start, 8'h00, cmd & 8'hdf, cso, len};
    endfunction
    // Complement of ones'-complement word sum, first byte high, odd tail padded
    function automatic logic [15:0] csum(input int s0, input int n);
        logic [16:0] s;
        s = 17'h0;
        for (int i = s0; i < n; i += 2)
            s = {1'b0, s[15:0]} + 17'(s[16]) + {1'b0, host_u.pat(i),
                (i + 1 < n) ? host_u.pat(i + 1) : 8'h00};
        s = {1'b0, s[15:0]} + 17'(s[16]);
        return ~s[15:0];
    endfunction
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(6'h00, 32'h0, "ctrl");
        rd(6'h08, 32'h8100, "vtype");
        bus(1'b1, 6'h18, 32'hffff_ffff);
        rd(6'h18, 32'h0, "unmapped");
        bus(1'b1, 6'h00, 32'h3);
        bus(1'b1, 6'h08, 32'h88a8);
        mark();
        host_u.send(mk(16'd5, 8'd0, 8'h00, 8'd1, 16'h0), 5, 0, 0);
        host_u.send(mk(16'd7, 8'd4, 8'h4d, 8'd0, 16'hbeef), 7, 2, 5);
        wt(n_irq, i0 + 1);
        chk("vlan_pkt", snap, {5'h0, 3'b111, 16'h88a8, 16'hbeef, csum(1, 12), 8'd4});
        chk("done", {flags_s[0], 8'(n_done - d0)}, {1'b1, 8'd1});
        rd(6'h14, {16'h88a8, 16'hbeef}, "tag_reg");
        bus(1'b1, 6'h00, 32'h2);
        mark();
        host_u.send(mk(16'd6, 8'd2, 8'h07, 8'd0, 16'h0), 6, 0, 0);
        wt(n_pkt, p0 + 1);
        chk("csum_pkt", snap, {8'h03, 32'h0, csum(0, 6), 8'd2}, {8'hff, 32'h0, 24'hffffff});
        rd(6'h10, {8'h00, 8'd2, csum(0, 6)}, "csum_reg");
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 6'h00, {30'h0, 1'b1, cm[c] == 8'h41 && c == 0 || c == 3});
            mark();
            host_u.send(mk(16'd4, 8'd0, cm[c], 8'd0, 16'h0), 4, 0, 0);
            wt(n_pkt, p0 + 1);
            chk("vlan_fcs", snap[58:56], ex[c]);
        end
        bus(1'b1, 6'h04, 32'd20);
        rd(6'h04, 32'd20, "delay_reg");
        mark();
        host_u.send(mk(16'd2, 8'd0, 8'h89, 8'd0, 16'h0), 2, 0, 0);
        repeat (8) @(posedge clk);
        host_u.send(mk(16'd2, 8'd0, 8'h89, 8'd0, 16'h0), 2, 0, 0);
        wt(n_irq, i0 + 1);
        chk("irq_delay", {(t_irq - t_done) inside {[18:22]}, 8'(n_done - d0)}, {1'b1, 8'd2});
        mark();
        host_u.send(mk(16'd2, 8'd0, 8'h89, 8'd0, 16'h0), 2, 0, 0);
        host_u.send(mk(16'd2, 8'd0, 8'h09, 8'd0, 16'h0), 2, 0, 0);
        repeat (40) @(posedge clk);
        chk("irq_clear", n_irq - i0, 1);
        bus(1'b1, 6'h00, 32'h4);
        mark();
        host_u.send(mk(16'd0, 8'd0, 8'h09, 8'd0, 16'h0), 0, 0, 0);
        repeat (30) @(posedge clk);
        chk("masked", {8'(n_irq - i0), 8'(n_done - d0)}, {8'd0, 8'd1});
        mark();
        host_u.send(mk(16'd2, 8'd0, 8'h10, 8'd0, 16'h0), 2, 0, 0);
        host_u.send(mk(16'd2, 8'd0, 8'h01, 8'd0, 16'h0), 2, 0, 0);
        wt(n_head, h0 + 2);
        chk("late_mid", n_done - d0, 0);
        for (int e = 0; e < 2; e++) begin
            mark();
            host_u.send(mk(16'd3, 8'd0, 8'h11, 8'd0, 16'h0), 3, 0, 0);
            repeat (12) @(posedge clk);
            chk("late_wait", n_done - d0 + n_head - h0, 0);
            sent_ok <= e == 0;
            sent_err <= e == 1;
            @(posedge clk);
            sent_ok <= 1'b0;
            sent_err <= 1'b0;
            wt(n_head, h0 + 1);
            chk("late_done", {flags_s[1:0], 8'(n_done - d0)}, {e[0], 1'b1, 8'd1});
        end
        final_report();
    end
endmodule // tb
`default_nettype wire
